// ### hdl/framer_pkg.sv
// constants and types shared by the framing core
package framer_pkg;
   localparam int FIFO_DEPTH = 96;
   localparam int PTR_W = 7;
   localparam logic [6:0] FIFO_LAST = 7'h5F;
   // SPI command bytes (device's own choice)
   localparam logic [7:0] CMD_FIFO_WR = 8'h80;
   localparam logic [7:0] CMD_FIFO_RD = 8'hBF;
   localparam logic [7:0] CMD_TX = 8'hC4;
   // protocol modes
   localparam logic [1:0] MODE_PARITY_CRC = 2'h0;
   localparam logic [1:0] MODE_CRC_ONLY = 2'h1;
   localparam logic [1:0] MODE_RAW = 2'h2;
   // bit period in clock cycles for each rate select
   localparam logic [7:0] BIT_CYC_0 = 8'h40;
   localparam logic [7:0] BIT_CYC_1 = 8'h20;
   localparam logic [7:0] BIT_CYC_2 = 8'h10;
   localparam logic [7:0] BIT_CYC_3 = 8'h08;
   localparam logic [15:0] CRC_INIT = 16'h6363;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [7:0] EOF_IDLE_BITS = 8'h03;
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_SOF = 4'h2,
      TX_BITS = 4'h4,
      TX_EOF = 4'h8
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h1,
      RX_BITS = 3'h2,
      RX_DONE = 3'h4
   } rx_state_t;
endpackage : framer_pkg

// ### hdl/nfc_framer.sv
// framing core with shared FIFO, SPI access and transparent bypass
`timescale 1ns/1ns
module nfc_framer (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // SPI from controller
   input wire logic i_sclk,
   input wire logic i_ss_b,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe,
   // configuration straps
   input wire logic [1:0] i_mode,
   input wire logic [1:0] i_rate,
   input wire logic i_transparent,
   input wire logic i_rx_on,
   input wire logic i_both_chan,
   input wire logic i_chan_pm,
   // receiver sub-carrier channels
   input wire logic i_rx_am,
   input wire logic i_rx_pm,
   // transmitter and status
   output logic o_mod,
   output logic o_tx_busy,
   output logic o_rx_frame_done,
   output logic o_err_parity,
   output logic o_err_crc,
   output logic o_err_frame,
   output logic o_irq
);
   // two-flop synchronisers for all asynchronous inputs except i_rst_b, i_mode, i_rate, i_both_chan and i_chan_pm
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic [6:0] sraw;
   assign sraw = {i_sclk, i_ss_b, i_mosi, i_rx_am, i_rx_pm, i_rx_on, i_transparent};
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_q <= 7'h20;
         s2_q <= 7'h20;
      end else begin
         s1_q <= sraw;
         s2_q <= s1_q;
      end
   end
   logic sclk_s, ssb_s, mosi_s, am_s, pm_s, rxon_s, trans_s;
   assign {sclk_s, ssb_s, mosi_s, am_s, pm_s, rxon_s, trans_s} = s2_q;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = ((c[0] ^ b) != 1'b0) ? ((c >> 1) ^ framer_pkg::CRC_POLY) : (c >> 1);
   endfunction : crc_step

   function automatic logic [7:0] bit_cycles(input logic [1:0] r);
      case (r)
         2'h0: bit_cycles = framer_pkg::BIT_CYC_0;
         2'h1: bit_cycles = framer_pkg::BIT_CYC_1;
         2'h2: bit_cycles = framer_pkg::BIT_CYC_2;
         default: bit_cycles = framer_pkg::BIT_CYC_3;
      endcase
   endfunction : bit_cycles

   // state registers
   logic sclk_d1_q, sclk_d1_d;
   logic [7:0] sh_q, sh_d, cmd_q, cmd_d, out_q, out_d;
   logic [2:0] scnt_q, scnt_d;
   logic have_cmd_q, have_cmd_d, miso_q, miso_d;
   logic [7:0] mem_q [0:framer_pkg::FIFO_DEPTH-1];
   logic [6:0] wp_q, wp_d, rp_q, rp_d, cnt_q, cnt_d;
   logic tx_dir_q, tx_dir_d;
   framer_pkg::tx_state_t ts_q, ts_d;
   framer_pkg::rx_state_t rs_q, rs_d;
   logic [7:0] tdiv_q, tdiv_d, tbyte_q, tbyte_d, rdiv_q, rdiv_d, rbyte_q, rbyte_d;
   logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
   logic [15:0] tcrc_q, tcrc_d, rcrc_q, rcrc_d;
   logic tpar_q, tpar_d, rpar_q, rpar_d, mod_q, mod_d, tcrc_ph_q, tcrc_ph_d;
   logic [1:0] tcrc_n_q, tcrc_n_d;
   logic rlast_q, rlast_d, done_q, done_d, ep_q, ep_d, ec_q, ec_d, ef_q, ef_d;
   logic wr_en, rd_en;
   logic [7:0] wr_data;
   logic sub;

   // channel choice: i_chan_pm takes pm alone, else i_both_chan takes the OR of both channels, else am alone
   always_comb begin
      if (i_both_chan && !i_chan_pm) sub = am_s | pm_s;
      else if (i_chan_pm) sub = pm_s;
      else sub = am_s;
   end

   // next state: SPI, FIFO, transmit and receive framers
   always_comb begin
      logic rise, fall, bit_end, rbit_end, rx_bit, last_byte, half;
      logic [7:0] full_sh;
      rise = sclk_s & ~sclk_d1_q;
      fall = ~sclk_s & sclk_d1_q;
      full_sh = {sh_q[6:0], mosi_s};
      bit_end = (tdiv_q == bit_cycles(i_rate) - 8'h01);
      half = (tdiv_q >= (bit_cycles(i_rate) >> 1)); // second half of a transmit bit
      rbit_end = (rdiv_q == (bit_cycles(i_rate) >> 1));
      rx_bit = sub;
      sclk_d1_d = sclk_s;
      sh_d = sh_q; cmd_d = cmd_q; out_d = out_q; scnt_d = scnt_q;
      have_cmd_d = have_cmd_q; miso_d = miso_q;
      wp_d = wp_q; rp_d = rp_q; cnt_d = cnt_q; tx_dir_d = tx_dir_q;
      ts_d = ts_q; rs_d = rs_q; tdiv_d = tdiv_q; tbyte_d = tbyte_q;
      rdiv_d = rdiv_q; rbyte_d = rbyte_q; tbit_d = tbit_q; rbit_d = rbit_q;
      tcrc_d = tcrc_q; rcrc_d = rcrc_q; tpar_d = tpar_q; rpar_d = rpar_q;
      mod_d = mod_q; tcrc_ph_d = tcrc_ph_q; tcrc_n_d = tcrc_n_q; rlast_d = sub;
      done_d = 1'b0; ep_d = ep_q; ec_d = ec_q; ef_d = ef_q;
      wr_en = 1'b0; rd_en = 1'b0; wr_data = 8'h00;
      last_byte = 1'b0;
      // SPI slave, mode 0, MSB first
      if (ssb_s) begin
         scnt_d = 3'h0; have_cmd_d = 1'b0;
      end else begin
         if (rise) begin
            sh_d = full_sh;
            scnt_d = scnt_q + 3'h1;
            if (scnt_q == 3'h7) begin
               if (!have_cmd_q) begin
                  have_cmd_d = 1'b1; cmd_d = full_sh;
                  if (full_sh == framer_pkg::CMD_TX && ts_q == framer_pkg::TX_IDLE) begin
                     ts_d = framer_pkg::TX_SOF; tdiv_d = 8'h00;
                     tcrc_d = framer_pkg::CRC_INIT; tcrc_ph_d = 1'b0;
                  end
                  if (full_sh == framer_pkg::CMD_FIFO_WR) begin
                     tx_dir_d = 1'b1; wp_d = 7'h00; rp_d = 7'h00; cnt_d = 7'h00;
                  end
               end else if (cmd_q == framer_pkg::CMD_FIFO_WR &&
                            cnt_q <= framer_pkg::FIFO_LAST) begin
                  wr_en = 1'b1; wr_data = full_sh;
               end
            end
         end
         if (fall) begin
            if (scnt_q == 3'h0 && have_cmd_q && cmd_q == framer_pkg::CMD_FIFO_RD) begin
               if (cnt_q != 7'h00 && !tx_dir_q) begin
                  out_d = mem_q[rp_q]; rd_en = 1'b1;
               end else out_d = 8'h00;
               miso_d = (cnt_q != 7'h00 && !tx_dir_q) ? mem_q[rp_q][7] : 1'b0;
            end else miso_d = out_q[7 - scnt_q];
         end
      end
      // transmit framer: SOF high bit, bytes LSB first, parity, CRC, EOF low bits
      tdiv_d = bit_end ? 8'h00 : tdiv_q + 8'h01;
      case (ts_q)
         framer_pkg::TX_IDLE: begin
            mod_d = 1'b0; tdiv_d = 8'h00;
         end
         framer_pkg::TX_SOF: begin
            mod_d = 1'b1;
            if (bit_end) begin
               if (cnt_q != 7'h00) begin
                  ts_d = framer_pkg::TX_BITS; tbyte_d = mem_q[rp_q]; rd_en = 1'b1;
                  tbit_d = 4'h0; tpar_d = 1'b1;
               end else ts_d = framer_pkg::TX_EOF;
               tcrc_n_d = 2'h0;
            end
         end
         framer_pkg::TX_BITS: begin
            if (tbit_q < 4'h8) mod_d = tbyte_q[tbit_q[2:0]] ^ half;
            else mod_d = tpar_q;
            if (bit_end) begin
               if (tbit_q < 4'h8) begin
                  tpar_d = tpar_q ^ tbyte_q[tbit_q[2:0]];
                  if (!tcrc_ph_q) tcrc_d = crc_step(tcrc_q, tbyte_q[tbit_q[2:0]]);
               end
               tbit_d = tbit_q + 4'h1;
               if (tbit_q == 4'h8 || (tbit_q == 4'h7 && i_mode != framer_pkg::MODE_PARITY_CRC)) begin
                  tbit_d = 4'h0; tpar_d = 1'b1;
                  if (!tcrc_ph_q && cnt_q != 7'h00) begin
                     tbyte_d = mem_q[rp_q]; rd_en = 1'b1;
                  end else if (i_mode != framer_pkg::MODE_RAW && tcrc_n_q != 2'h2) begin
                     tcrc_ph_d = 1'b1; tcrc_n_d = tcrc_n_q + 2'h1;
                     tbyte_d = (tcrc_n_q == 2'h0) ? ~tcrc_d[7:0] : ~tcrc_q[15:8];
                  end else ts_d = framer_pkg::TX_EOF;
               end
            end
         end
         framer_pkg::TX_EOF: begin
            mod_d = 1'b0;
            if (bit_end) begin
               tbit_d = tbit_q + 4'h1;
               if (tbit_q[1:0] == framer_pkg::EOF_IDLE_BITS[1:0]) begin
                  ts_d = framer_pkg::TX_IDLE; tx_dir_d = 1'b0;
               end
            end
         end
         default: ts_d = framer_pkg::TX_IDLE;
      endcase
      // receive framer: SOF is a first edge, bits sampled mid period
      rdiv_d = (rdiv_q == bit_cycles(i_rate) - 8'h01) ? 8'h00 : rdiv_q + 8'h01;
      case (rs_q)
         framer_pkg::RX_IDLE: begin
            rdiv_d = 8'h00;
            if (rxon_s && !trans_s && !tx_dir_q && sub && !rlast_q) begin
               rs_d = framer_pkg::RX_BITS; rbit_d = 4'h0; rpar_d = 1'b1;
               rcrc_d = framer_pkg::CRC_INIT; ep_d = 1'b0; ec_d = 1'b0; ef_d = 1'b0;
               wp_d = 7'h00; rp_d = 7'h00; cnt_d = 7'h00;
            end
         end
         framer_pkg::RX_BITS: begin
            if (!rxon_s) rs_d = framer_pkg::RX_DONE;
            else if (rbit_end) begin
               if (rbit_q < 4'h8) begin
                  rbyte_d = {rx_bit, rbyte_q[7:1]};
                  rpar_d = rpar_q ^ rx_bit;
                  rcrc_d = crc_step(rcrc_q, rx_bit);
               end
               rbit_d = rbit_q + 4'h1;
               last_byte = (rbit_q == 4'h8) ||
                           (rbit_q == 4'h7 && i_mode != framer_pkg::MODE_PARITY_CRC);
               if (last_byte) begin
                  if (rbit_q == 4'h8 && rx_bit != rpar_q) ep_d = 1'b1;
                  wr_en = 1'b1; rbit_d = 4'h0; rpar_d = 1'b1;
                  wr_data = (rbit_q == 4'h8) ? rbyte_q : {rx_bit, rbyte_q[7:1]};
                  if (cnt_q > framer_pkg::FIFO_LAST) ef_d = 1'b1;
               end
            end
         end
         framer_pkg::RX_DONE: begin
            rs_d = framer_pkg::RX_IDLE; done_d = 1'b1;
            if (rbit_q != 4'h0) ef_d = 1'b1;
            if (i_mode != framer_pkg::MODE_RAW && rcrc_q != 16'h0000) ec_d = 1'b1;
         end
         default: rs_d = framer_pkg::RX_IDLE;
      endcase
      if (wr_en && cnt_q <= framer_pkg::FIFO_LAST) begin
         wp_d = (wp_q == framer_pkg::FIFO_LAST) ? 7'h00 : wp_q + 7'h01;
      end
      if (rd_en) rp_d = (rp_q == framer_pkg::FIFO_LAST) ? 7'h00 : rp_q + 7'h01;
      if ((wr_en && cnt_q <= framer_pkg::FIFO_LAST) && !rd_en) cnt_d = cnt_d + 7'h01;
      else if (rd_en && !(wr_en && cnt_q <= framer_pkg::FIFO_LAST)) cnt_d = cnt_d - 7'h01;
   end

   // FIFO storage
   always_ff @(posedge i_clk) begin
      if (wr_en && cnt_q <= framer_pkg::FIFO_LAST) mem_q[wp_q] <= wr_data;
   end

   // register all control state
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sclk_d1_q <= 1'b0; sh_q <= 8'h00; cmd_q <= 8'h00; out_q <= 8'h00;
         scnt_q <= 3'h0; have_cmd_q <= 1'b0; miso_q <= 1'b0;
         wp_q <= 7'h00; rp_q <= 7'h00; cnt_q <= 7'h00; tx_dir_q <= 1'b0;
         ts_q <= framer_pkg::TX_IDLE; rs_q <= framer_pkg::RX_IDLE;
         tdiv_q <= 8'h00; tbyte_q <= 8'h00; rdiv_q <= 8'h00; rbyte_q <= 8'h00;
         tbit_q <= 4'h0; rbit_q <= 4'h0; tcrc_q <= 16'h0000; rcrc_q <= 16'h0000;
         tpar_q <= 1'b0; rpar_q <= 1'b0; mod_q <= 1'b0; tcrc_ph_q <= 1'b0;
         tcrc_n_q <= 2'h0; rlast_q <= 1'b0; done_q <= 1'b0;
         ep_q <= 1'b0; ec_q <= 1'b0; ef_q <= 1'b0;
      end else begin
         sclk_d1_q <= sclk_d1_d; sh_q <= sh_d; cmd_q <= cmd_d; out_q <= out_d;
         scnt_q <= scnt_d; have_cmd_q <= have_cmd_d; miso_q <= miso_d;
         wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d; tx_dir_q <= tx_dir_d;
         ts_q <= ts_d; rs_q <= rs_d;
         tdiv_q <= tdiv_d; tbyte_q <= tbyte_d; rdiv_q <= rdiv_d; rbyte_q <= rbyte_d;
         tbit_q <= tbit_d; rbit_q <= rbit_d; tcrc_q <= tcrc_d; rcrc_q <= rcrc_d;
         tpar_q <= tpar_d; rpar_q <= rpar_d; mod_q <= mod_d; tcrc_ph_q <= tcrc_ph_d;
         tcrc_n_q <= tcrc_n_d; rlast_q <= rlast_d; done_q <= done_d;
         ep_q <= ep_d; ec_q <= ec_d; ef_q <= ef_d;
      end
   end

   // outputs; transparent mode bypasses framing and FIFO
   assign o_miso = trans_s ? sub : miso_q;
   assign o_miso_oe = ~ssb_s | trans_s;
   assign o_mod = trans_s ? mosi_s : mod_q;
   assign o_tx_busy = (ts_q != framer_pkg::TX_IDLE);
   assign o_rx_frame_done = done_q;
   assign o_err_parity = ep_q;
   assign o_err_crc = ec_q;
   assign o_err_frame = ef_q;
   assign o_irq = done_q & (ep_q | ec_q | ef_q);
endmodule : nfc_framer

// ### sim/nfc_framer_props.sv
// port checker for the framing core
`timescale 1ns/1ns
module nfc_framer_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // watched inputs
   input wire logic i_ss_b,
   input wire logic i_mosi,
   input wire logic i_transparent,
   input wire logic i_rx_on,
   input wire logic i_both_chan,
   input wire logic i_chan_pm,
   input wire logic i_rx_am,
   // watched outputs
   input wire logic o_miso,
   input wire logic o_miso_oe,
   input wire logic o_mod,
   input wire logic o_tx_busy,
   input wire logic o_rx_frame_done,
   input wire logic o_err_parity,
   input wire logic o_err_crc,
   input wire logic o_err_frame,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // any latched receive error
   wire logic any_err = o_err_parity | o_err_crc | o_err_frame;
   // start marker holds the line high
   sequence s_sof_high;
      o_mod [*6];
   endsequence
   property p_sof;
      $rose(o_tx_busy) |-> ##1 s_sof_high;
   endproperty
   a_sof: assert property (p_sof) else $error("start marker not high");
   property p_oe_on;
      (!i_ss_b || i_transparent) [*4] |-> o_miso_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven");
   property p_oe_off;
      (i_ss_b && !i_transparent) [*4] |-> !o_miso_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
   property p_miso;
      (i_transparent && !i_both_chan && !i_chan_pm && $stable(i_rx_am)) [*4] |-> o_miso == i_rx_am;
   endproperty
   a_miso: assert property (p_miso) else $error("bypass to miso broken");
   property p_mod;
      (i_transparent && $stable(i_mosi)) [*4] |-> o_mod == i_mosi;
   endproperty
   a_mod: assert property (p_mod) else $error("bypass to modulator broken");
   property p_mod_idle;
      (!o_tx_busy && !i_transparent) [*4] |-> !o_mod;
   endproperty
   a_mod_idle: assert property (p_mod_idle) else $error("modulation while idle");
   property p_done_pulse;
      o_rx_frame_done |=> !o_rx_frame_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("frame end too long");
   property p_done_cause;
      o_rx_frame_done |-> $past(i_rx_on, 2) == 1'b0;
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("frame end without qualifier");
   property p_irq;
      o_irq == (o_rx_frame_done && any_err);
   endproperty
   a_irq: assert property (p_irq) else $error("irq not tied to errors");
endmodule : nfc_framer_props

bind nfc_framer nfc_framer_props u_props (.i_clk, .i_rst_b, .i_ss_b, .i_mosi, .i_transparent,
   .i_rx_on, .i_both_chan, .i_chan_pm, .i_rx_am, .o_miso, .o_miso_oe, .o_mod, .o_tx_busy,
   .o_rx_frame_done, .o_err_parity, .o_err_crc, .o_err_frame, .o_irq);

// ### sim/spi_mcu.sv
// controller model: spi mode 0 master and bypass modulation source
`timescale 1ns/1ns
module spi_mcu (
   // clock
   input wire logic i_clk,
   // spi wires
   output logic o_sclk,
   output logic o_ss_b,
   output logic o_mosi,
   input wire logic i_miso
);
   // idle wires at time zero
   initial begin
      o_sclk = 1'b0;
      o_ss_b = 1'b1;
      o_mosi = 1'b0;
   end
   // one byte msb first, eight clocks per sclk period
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi <= tx[i];
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_clk);
         rx[i] = i_miso;
         o_sclk <= 1'b0;
      end
   endtask : xfer
   // selected burst of bytes, last read byte returned
   task automatic burst(input logic [7:0] q[$], output logic [7:0] last);
      @(posedge i_clk);
      o_ss_b <= 1'b0;
      foreach (q[k]) xfer(q[k], last);
      repeat (4) @(posedge i_clk);
      o_ss_b <= 1'b1;
      o_mosi <= ~o_mosi; // released line does not keep its value
      repeat (4) @(posedge i_clk); // deselect time before the next burst
   endtask : burst
   // bypass modulation level
   task automatic set_mosi(input logic v);
      @(posedge i_clk);
      o_mosi <= v;
   endtask : set_mosi
endmodule : spi_mcu

// ### sim/nfc_framer_tb.sv
// self-checking bench for the framing core
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
$display("BAD %0t got %0h exp %0h", $time, g, e); end end
module nfc_framer_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sclk, ss_b, mosi, miso, miso_oe, mod, busy, done, e_par, e_crc, e_frm, irq;
   logic [1:0] mode = 2'h0;
   logic [1:0] rate = 2'h3;
   logic transp = 1'b0;
   logic rx_on = 1'b0;
   logic both = 1'b1;
   logic chan_pm = 1'b0;
   logic rx_am = 1'b0;
   logic rx_pm = 1'b0;
   int bad_count = 0;
   int n_compared = 0;
   int busy_cyc = 0;
   // 50 MHz clock and busy cycle count
   always #10 clk = ~clk;
   always @(posedge clk) if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
   nfc_framer u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_ss_b(ss_b), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe(miso_oe), .i_mode(mode), .i_rate(rate), .i_transparent(transp),
      .i_rx_on(rx_on), .i_both_chan(both), .i_chan_pm(chan_pm), .i_rx_am(rx_am), .i_rx_pm(rx_pm),
      .o_mod(mod), .o_tx_busy(busy), .o_rx_frame_done(done), .o_err_parity(e_par),
      .o_err_crc(e_crc), .o_err_frame(e_frm), .o_irq(irq));
   spi_mcu u_mcu (.i_clk(clk), .o_sclk(sclk), .o_ss_b(ss_b), .o_mosi(mosi), .i_miso(miso));
   // bounded wait for the frame end pulse
   task automatic wait_done(input int lim, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(posedge clk);
         seen = (done === 1'b1);
      end
   endtask : wait_done
   // reading in transmit direction yields zero
   task automatic t_dir;
      logic [7:0] d;
      u_mcu.burst({framer_pkg::CMD_FIFO_WR, 8'hA5}, d);
      u_mcu.burst({framer_pkg::CMD_FIFO_RD, 8'h00}, d);
      `CHK(d, 8'h00)
      $display("end: fifo direction");
   endtask : t_dir
   // load n bytes, send, measure frame length in bit periods
   task automatic t_tx(input logic [1:0] m, input logic [1:0] r, input int n, input int nbits);
      logic [7:0] q[$];
      logic [7:0] d;
      int per;
      int start;
      int i;
      per = 64 >> r;
      mode <= m;
      rate <= r;
      q = {framer_pkg::CMD_FIFO_WR};
      for (i = 0; i < n; i++) q.push_back(8'h3C + 8'(i));
      u_mcu.burst(q, d);
      start = busy_cyc;
      u_mcu.burst({framer_pkg::CMD_TX}, d);
      for (i = 0; i < 20000 && !(busy_cyc > start && busy === 1'b0); i++) @(posedge clk);
      `CHK((busy_cyc - start + per / 2) / per, nbits + 5)
      $display("end: transmit mode %0d", m);
   endtask : t_tx
   // qualifier gating, frame via second channel, error flags
   task automatic t_rx;
      logic seen;
      mode <= framer_pkg::MODE_CRC_ONLY;
      rate <= 2'h3;
      rx_pm <= 1'b1; // edge while qualifier low
      repeat (24) @(posedge clk);
      rx_pm <= 1'b0;
      rx_on <= 1'b1;
      repeat (16) @(posedge clk);
      rx_on <= 1'b0;
      wait_done(20, seen);
      `CHK(seen, 1'b0)
      rx_on <= 1'b1;
      repeat (8) @(posedge clk);
      rx_pm <= 1'b1;
      repeat (24) @(posedge clk);
      rx_pm <= 1'b0;
      repeat (8) @(posedge clk);
      rx_on <= 1'b0;
      wait_done(20, seen);
      `CHK({seen, irq, e_frm, e_crc}, 4'hF)
      rx_on <= 1'b1;
      repeat (8) @(posedge clk);
      rx_am <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK({e_par, e_crc, e_frm}, 3'h0)
      rx_on <= 1'b0;
      rx_am <= 1'b0;
      wait_done(20, seen);
      $display("end: receive");
   endtask : t_rx
   // one byte on the am channel after a start pulse, then read back over spi
   task automatic t_rx_byte(input logic [1:0] m, input logic [8:0] v, input int nb,
                            input logic perr);
      logic seen;
      logic [7:0] d;
      mode <= m;
      rx_on <= 1'b1;
      repeat (8) @(posedge clk);
      rx_am <= 1'b1; // start edge
      @(posedge clk);
      for (int k = 0; k < nb; k++) begin
         rx_am <= v[k];
         repeat (8) @(posedge clk);
      end
      rx_on <= 1'b0;
      rx_am <= 1'b0;
      wait_done(20, seen);
      `CHK({seen, irq, e_par, e_frm}, {1'b1, perr, perr, 1'b0})
      u_mcu.burst({framer_pkg::CMD_FIFO_RD, 8'h00}, d);
      `CHK(d, v[7:0])
      $display("end: receive byte mode %0d", m);
   endtask : t_rx_byte
   // bypass of framing in both directions
   task automatic t_transp;
      transp <= 1'b1;
      both <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         u_mcu.set_mosi(k[0]);
         chan_pm <= k[1]; // second half takes the pm channel only
         rx_am <= ~k[0] ^ k[1];
         rx_pm <= k[0] ^ k[1];
         repeat (6) @(posedge clk);
         `CHK({mod, miso, miso_oe}, {k[0], ~k[0], 1'b1})
      end
      transp <= 1'b0;
      chan_pm <= 1'b0;
      rx_pm <= 1'b0;
      $display("end: transparent");
   endtask : t_transp
   // verdict and end of run
   task automatic tally_and_finish;
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK({busy, done, irq, mod, miso_oe, e_par, e_crc, e_frm}, 8'h00)
      t_dir();
      t_tx(framer_pkg::MODE_PARITY_CRC, 2'h3, 2, 36);
      t_tx(framer_pkg::MODE_PARITY_CRC, 2'h1, 1, 27);
      t_tx(framer_pkg::MODE_CRC_ONLY, 2'h2, 2, 32);
      t_tx(framer_pkg::MODE_RAW, 2'h0, 1, 8);
      t_tx(framer_pkg::MODE_RAW, 2'h3, 97, 768);
      t_rx();
      t_rx_byte(framer_pkg::MODE_RAW, 9'h03C, 8, 1'b0);
      t_rx_byte(framer_pkg::MODE_PARITY_CRC, 9'h0A5, 9, 1'b1);
      t_transp();
      tally_and_finish();
   end
   // watchdog, about six times the expected run
   initial begin
      #2000000;
      bad_count++;
      tally_and_finish();
   end
endmodule : nfc_framer_tb
